// *** design/power_mode_clock_params.svh ***
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit word-aligned register window behind an ahb-lite slave
`ifndef POWER_MODE_CLOCK_PARAMS_SVH
`define POWER_MODE_CLOCK_PARAMS_SVH

// register byte offsets
`define MODE_OFS 8'h00
`define CLKSEL_OFS 8'h04
`define GATE_OFS 8'h08
`define WAKEEN_OFS 8'h0C
`define RSTEN_OFS 8'h10
`define STATUS_OFS 8'h14
`define CAUSE_OFS 8'h18

// mode register fields
`define MODE_RAM_RUN 0
`define MODE_BUS_HALT 1
`define MODE_FAST_WAKE 2
`define MODE_FAST_RTC 3
`define MODE_DEEP_SLEEP 4
`define MODE_PM_SELECT 5
`define MODE_RST 6'h00

// clock select fields
`define CLKSEL_SRC_LSB 0
`define CLKSEL_DIV_LSB 4
`define CLKSEL_APB_HALF 8
`define SRC_RST 3'h2
`define DIV_RST 4'h0

// gate register: apb enables low half, ahb enables high half
`define GATE_AHB_LSB 16
`define GATE_RST 32'h0001_0001
`define PORT_GATE_BIT 0

// wake source bits
`define WAKE_LPT 0
`define WAKE_RTC_ALARM 1
`define WAKE_RTC_FAIL 2
`define WAKE_CMP0 3
`define WAKE_PIN 4
`define WAKE_SUPPLY_LOW 5
`define WAKE_REG_LOW 6
`define WAKE_PORT 7
`define WAKE_NOAPB_MASK 8'h67
`define WAKEEN_RST 8'h00
`define RSTEN_RST 4'h0

// clock source codes and nominal rates in mhz
`define SRC_RTC 3'h0
`define SRC_LFO 3'h1
`define SRC_LPO 3'h2
`define SRC_LPO_DIV 3'h3
`define SRC_EXT 3'h4
`define SRC_PLL 3'h5
`define SRC_RTC_MHZ 8'h00
`define SRC_LFO_MHZ 8'h00
`define SRC_LPO_MHZ 8'h14
`define SRC_LPO_DIV_MHZ 8'h03
`define SRC_EXT_MHZ 8'h19
`define SRC_PLL_MHZ 8'h50
`define APB_FULL_MAX_MHZ 8'h32

// reported power mode numbers
`define PM_NUM_RUN 4'h0
`define PM_NUM_RAM 4'h1
`define PM_NUM_CORE 4'h2
`define PM_NUM_BUS 4'h3
`define PM_NUM_DEEP 4'h9

// timing
`define CLK_PERIOD_NS 4
`define SWITCH_GAP_NS 16
`define SWITCH_GAP_CYC ((`SWITCH_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_SETTLE_NS 40
`define WAKE_SETTLE_CYC ((`WAKE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** design/power_mode_clock_pkg.sv ***
// types shared by the power mode and clock sequencer
// assumes the params header supplies all numeric constants
package power_mode_clock_pkg;

   // sequencer states
   typedef enum logic [2:0] {
      ST_RUN,
      ST_CORE_SLEEP,
      ST_BUS_SLEEP,
      ST_WAKING,
      ST_DEEP
   } pwr_state_t;

   typedef logic [2:0] clk_src_t;

endpackage : power_mode_clock_pkg

// *** design/clk_ctrl_if.sv ***
// carrier between the sequencer and its clock strobe generator
// assumes both ends run on the same system clock
`timescale 1ns/10ps
`default_nettype none

interface clk_ctrl_if;
   import power_mode_clock_pkg::*;
   clk_src_t src;
   logic [3:0] div;
   logic apbHalf;
   logic run;
   logic ahbTick;
   logic apbTick;
   logic switching;
   clk_src_t activeSrc;

   modport ctrl (output src, div, apbHalf, run, input ahbTick, apbTick, switching, activeSrc);
   modport gen (input src, div, apbHalf, run, output ahbTick, apbTick, switching, activeSrc);
endinterface : clk_ctrl_if

`default_nettype wire

// *** design/sync2.sv ***
// two-flop synchroniser for a bus of independent levels
// assumes each bit is a slow level from outside the clock domain
`timescale 1ns/10ps
`default_nettype none

module sync2 #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // first stage feeds only the second
   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule : sync2

`default_nettype wire

// *** design/clock_tick_gen.sv ***
// bus clock strobe generator with glitch-free source and divider switching
// assumes downstream gating cells use the strobes as clock enables
`timescale 1ns/10ps
`default_nettype none
`include "power_mode_clock_params.svh"

module clock_tick_gen
   import power_mode_clock_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   clk_ctrl_if.gen cc
);
   localparam logic [3:0] GAP = 4'(`SWITCH_GAP_CYC);

   clk_src_t curSrc_ff;
   logic [3:0] curDiv_ff;
   logic [3:0] gapCnt_ff;
   logic [3:0] divCnt_ff;
   logic apbPhase_ff;
   logic reqChange;
   logic switching;
   logic ahbTick;

   assign reqChange = (cc.src != curSrc_ff) || (cc.div != curDiv_ff);
   assign switching = (gapCnt_ff != 4'h0);

   // quiet gap before every change, then take the new setting
   always_ff @(posedge mclk) begin
      if (rst) begin
         curSrc_ff <= `SRC_RST;
         curDiv_ff <= `DIV_RST;
         gapCnt_ff <= 4'h0;
      end else if (switching) begin
         gapCnt_ff <= gapCnt_ff - 4'h1;
         if (gapCnt_ff == 4'h1) begin
            curSrc_ff <= cc.src;
            curDiv_ff <= cc.div;
         end
      end else if (reqChange) begin
         gapCnt_ff <= GAP;
      end
   end

   // divider restarts cleanly after each switch
   always_ff @(posedge mclk) begin
      if (rst || switching || !cc.run) begin
         divCnt_ff <= 4'h0;
      end else if (divCnt_ff == curDiv_ff) begin
         divCnt_ff <= 4'h0;
      end else begin
         divCnt_ff <= divCnt_ff + 4'h1;
      end
   end

   // apb phase realigns with ahb after a switch
   always_ff @(posedge mclk) begin
      if (rst || switching) begin
         apbPhase_ff <= 1'b0;
      end else if (ahbTick) begin
         apbPhase_ff <= !apbPhase_ff;
      end
   end

   assign ahbTick = cc.run && !switching && (divCnt_ff == 4'h0);
   assign cc.ahbTick = ahbTick;
   assign cc.apbTick = ahbTick && (!cc.apbHalf || !apbPhase_ff);
   assign cc.switching = switching;
   assign cc.activeSrc = curSrc_ff;
endmodule : clock_tick_gen

`default_nettype wire

// *** design/power_mode_clock_sequencer.sv ***
// power mode sequencer, bus clock selection and per-peripheral clock gating
// assumes an ahb-lite master with single word transfers and one system clock
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "power_mode_clock_params.svh"

module power_mode_clock_sequencer
   import power_mode_clock_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic waitInstr,
   input wire logic [7:0] wakeSrcIn,
   input wire logic [3:0] resetSrcIn,
   input wire logic [15:0] periphReq,
   output logic [15:0] periphGrant,
   output logic [15:0] ahbGateEn,
   output logic [15:0] apbGateEn,
   output logic ahbTick,
   output logic apbTick,
   output logic [2:0] activeSrc,
   output logic coreHalt,
   output logic fetchFromRam,
   output logic lpOscSuspend,
   output logic pinLowPower,
   output logic ramRetainOnly,
   output logic sysResetReq,
   output logic [3:0] powerMode
);
   localparam logic [3:0] SETTLE = 4'(`WAKE_SETTLE_CYC);

   clk_ctrl_if cc ();

   pwr_state_t state_ff;
   pwr_state_t nxt_state;
   logic [5:0] mode_ff;
   clk_src_t src_ff;
   logic [3:0] div_ff;
   logic apbDiv2_ff;
   logic [31:0] gate_ff;
   logic [7:0] wakeEn_ff;
   logic [3:0] rstEn_ff;
   logic [7:0] cause_ff;
   logic [3:0] settle_ff;
   logic wrPend_ff;
   logic [7:0] wrAddr_ff;
   logic [31:0] hrdata_ff;
   logic [15:0] ahbGate_ff;
   logic [15:0] apbGate_ff;
   logic [15:0] grant_ff;
   logic resetReq_ff;
   logic [3:0] pmNum_ff;
   logic [7:0] wakeSync;
   logic [3:0] resetSync;
   logic [7:0] wakeQual;
   logic [7:0] coreWakeHits;
   logic [7:0] busWakeHits;
   logic addrPhase;
   logic wrMode;
   logic wrClk;
   logic wrGate;
   logic wrWake;
   logic wrRst;
   logic wrCause;
   logic [7:0] srcMhz;
   logic [11:0] apbLimit;
   logic ahbFast;
   logic fastSleep;
   logic fastWaking;
   logic busRunning;
   logic [31:0] readMux;
   logic nxt_ramRun;

   // wake and reset pins come from other domains
   sync2 #(.W(8)) wakeSyncInst (
      .mclk(mclk),
      .rst(rst),
      .d(wakeSrcIn),
      .q(wakeSync)
   );

   sync2 #(.W(4)) resetSyncInst (
      .mclk(mclk),
      .rst(rst),
      .d(resetSrcIn),
      .q(resetSync)
   );

   clock_tick_gen tickGen (
      .mclk(mclk),
      .rst(rst),
      .cc(cc.gen)
   );

   // ahb-lite address phase decode, zero wait state
   assign addrPhase = hsel && htrans[1] && hready;

   always_ff @(posedge mclk) begin
      if (rst) begin
         wrPend_ff <= 1'b0;
         wrAddr_ff <= 8'h00;
      end else begin
         wrPend_ff <= addrPhase && hwrite;
         if (addrPhase) begin
            wrAddr_ff <= haddr[7:0];
         end
      end
   end

   assign wrMode = wrPend_ff && (wrAddr_ff == `MODE_OFS);
   assign wrClk = wrPend_ff && (wrAddr_ff == `CLKSEL_OFS);
   assign wrGate = wrPend_ff && (wrAddr_ff == `GATE_OFS);
   assign wrWake = wrPend_ff && (wrAddr_ff == `WAKEEN_OFS);
   assign wrRst = wrPend_ff && (wrAddr_ff == `RSTEN_OFS);
   assign wrCause = wrPend_ff && (wrAddr_ff == `CAUSE_OFS);

   // mode control register
   always_ff @(posedge mclk) begin
      if (rst) begin
         mode_ff <= `MODE_RST;
      end else if (wrMode) begin
         mode_ff <= hwdata[5:0];
      end
   end

   // clock source, divider and apb half select
   always_ff @(posedge mclk) begin
      if (rst) begin
         src_ff <= `SRC_RST;
         div_ff <= `DIV_RST;
         apbDiv2_ff <= 1'b0;
      end else if (wrClk) begin
         src_ff <= hwdata[`CLKSEL_SRC_LSB +: 3];
         div_ff <= hwdata[`CLKSEL_DIV_LSB +: 4];
         apbDiv2_ff <= hwdata[`CLKSEL_APB_HALF];
      end
   end

   // peripheral clock gates, kept across sleep
   always_ff @(posedge mclk) begin
      if (rst) begin
         gate_ff <= `GATE_RST;
      end else if (wrGate) begin
         gate_ff <= hwdata;
      end
   end

   // wake and reset source enables
   always_ff @(posedge mclk) begin
      if (rst) begin
         wakeEn_ff <= `WAKEEN_RST;
         rstEn_ff <= `RSTEN_RST;
      end else begin
         if (wrWake) begin
            wakeEn_ff <= hwdata[7:0];
         end
         if (wrRst) begin
            rstEn_ff <= hwdata[3:0];
         end
      end
   end

   // port events wake only while the port apb clock stays on
   always_comb begin
      wakeQual = wakeSync & wakeEn_ff;
      wakeQual[`WAKE_PORT] = wakeSync[`WAKE_PORT] && wakeEn_ff[`WAKE_PORT]
         && gate_ff[`PORT_GATE_BIT];
   end

   assign coreWakeHits = wakeQual;
   assign busWakeHits = wakeQual & `WAKE_NOAPB_MASK;

   // source rate lookup for the apb limit
   always_comb begin
      unique case (src_ff)
         `SRC_RTC: srcMhz = `SRC_RTC_MHZ;
         `SRC_LFO: srcMhz = `SRC_LFO_MHZ;
         `SRC_LPO: srcMhz = `SRC_LPO_MHZ;
         `SRC_LPO_DIV: srcMhz = `SRC_LPO_DIV_MHZ;
         `SRC_EXT: srcMhz = `SRC_EXT_MHZ;
         `SRC_PLL: srcMhz = `SRC_PLL_MHZ;
         default: srcMhz = `SRC_PLL_MHZ; // unused codes treated as fastest
      endcase
   end

   // ahb rate is src / (div + 1); compare without dividing
   assign apbLimit = 12'(`APB_FULL_MAX_MHZ) * (12'(div_ff) + 12'h001);
   assign ahbFast = 12'(srcMhz) > apbLimit;

   // sequencer next state
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_RUN: begin
            if (waitInstr) begin
               if (mode_ff[`MODE_DEEP_SLEEP] && mode_ff[`MODE_PM_SELECT]) begin
                  nxt_state = ST_DEEP;
               end else if (mode_ff[`MODE_BUS_HALT]) begin
                  nxt_state = ST_BUS_SLEEP;
               end else begin
                  nxt_state = ST_CORE_SLEEP;
               end
            end
         end
         ST_CORE_SLEEP: begin
            if (coreWakeHits != 8'h00) begin
               nxt_state = ST_RUN;
            end
         end
         ST_BUS_SLEEP: begin
            if (busWakeHits != 8'h00) begin
               nxt_state = ST_WAKING;
            end
         end
         ST_WAKING: begin
            if (settle_ff == 4'h0) begin
               nxt_state = ST_RUN;
            end
         end
         ST_DEEP: begin
            nxt_state = ST_DEEP;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_ff <= ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // bus clock restore time after bus sleep
   always_ff @(posedge mclk) begin
      if (rst) begin
         settle_ff <= 4'h0;
      end else if (state_ff == ST_BUS_SLEEP) begin
         settle_ff <= SETTLE;
      end else if (state_ff == ST_WAKING && settle_ff != 4'h0) begin
         settle_ff <= settle_ff - 4'h1;
      end
   end

   // wake causes: sticky, write one to clear, a new hit wins
   always_ff @(posedge mclk) begin
      if (rst) begin
         cause_ff <= 8'h00;
      end else begin
         cause_ff <= (cause_ff & ~(wrCause ? hwdata[7:0] : 8'h00))
            | ((state_ff == ST_CORE_SLEEP) ? coreWakeHits : 8'h00)
            | ((state_ff == ST_BUS_SLEEP) ? busWakeHits : 8'h00);
      end
   end

   // only an enabled reset source ends deep sleep
   always_ff @(posedge mclk) begin
      if (rst) begin
         resetReq_ff <= 1'b0;
      end else if (state_ff == ST_DEEP && (resetSync & rstEn_ff) != 4'h0) begin
         resetReq_ff <= 1'b1;
      end
   end

   // clock request towards the strobe generator
   assign fastSleep = (state_ff == ST_BUS_SLEEP) && mode_ff[`MODE_FAST_WAKE];
   assign fastWaking = (state_ff == ST_WAKING) && mode_ff[`MODE_FAST_WAKE];

   always_comb begin
      if (fastSleep) begin
         cc.src = mode_ff[`MODE_FAST_RTC] ? `SRC_RTC : `SRC_LFO;
         cc.div = 4'h0;
      end else if (fastWaking) begin
         cc.src = `SRC_LPO;
         cc.div = 4'h0;
      end else begin
         cc.src = src_ff;
         cc.div = div_ff;
      end
   end

   assign cc.apbHalf = apbDiv2_ff || ahbFast;
   assign cc.run = (state_ff != ST_DEEP);
   assign busRunning = (state_ff != ST_BUS_SLEEP) && (state_ff != ST_DEEP);

   // registered per-peripheral clock enables
   always_ff @(posedge mclk) begin
      if (rst) begin
         ahbGate_ff <= 16'h0000;
         apbGate_ff <= 16'h0000;
      end else if (busRunning) begin
         ahbGate_ff <= gate_ff[`GATE_AHB_LSB +: 16];
         apbGate_ff <= gate_ff[15:0];
      end else begin
         ahbGate_ff <= 16'h0000;
         apbGate_ff <= 16'h0000;
      end
   end

   // accesses to a gated peripheral wait for its clocks
   always_ff @(posedge mclk) begin
      if (rst) begin
         grant_ff <= 16'h0000;
      end else begin
         grant_ff <= periphReq & ahbGate_ff & apbGate_ff;
      end
   end

   // ram run bit as it stands after this edge, so the report never lags the mode
   assign nxt_ramRun = wrMode ? hwdata[`MODE_RAM_RUN] : mode_ff[`MODE_RAM_RUN];

   // reported mode number
   always_ff @(posedge mclk) begin
      if (rst) begin
         pmNum_ff <= `PM_NUM_RUN;
      end else begin
         unique case (nxt_state)
            ST_RUN: pmNum_ff <= nxt_ramRun ? `PM_NUM_RAM : `PM_NUM_RUN;
            ST_CORE_SLEEP: pmNum_ff <= `PM_NUM_CORE;
            ST_BUS_SLEEP: pmNum_ff <= `PM_NUM_BUS;
            ST_WAKING: pmNum_ff <= `PM_NUM_BUS;
            ST_DEEP: pmNum_ff <= `PM_NUM_DEEP;
         endcase
      end
   end

   // read mux, unmapped offsets read zero
   always_comb begin
      readMux = 32'h0000_0000;
      unique case (haddr[7:0])
         `MODE_OFS: readMux = {26'h000_0000, mode_ff};
         `CLKSEL_OFS: readMux = {23'h00_0000, apbDiv2_ff, div_ff, 1'b0, src_ff};
         `GATE_OFS: readMux = gate_ff;
         `WAKEEN_OFS: readMux = {24'h00_0000, wakeEn_ff};
         `RSTEN_OFS: readMux = {28'h000_0000, rstEn_ff};
         `STATUS_OFS: readMux = {23'h00_0000, cc.apbHalf, cc.switching, cc.activeSrc, pmNum_ff};
         `CAUSE_OFS: readMux = {24'h00_0000, cause_ff};
         default: readMux = 32'h0000_0000;
      endcase
   end

   // read data registered into the data phase
   always_ff @(posedge mclk) begin
      if (rst) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (addrPhase && !hwrite) begin
         hrdata_ff <= readMux;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;

   // mode outputs
   assign coreHalt = (state_ff != ST_RUN);
   assign fetchFromRam = mode_ff[`MODE_RAM_RUN];
   assign lpOscSuspend = (state_ff == ST_BUS_SLEEP) || (state_ff == ST_DEEP);
   assign pinLowPower = (state_ff == ST_DEEP);
   assign ramRetainOnly = (state_ff == ST_DEEP);
   assign sysResetReq = resetReq_ff;
   assign powerMode = pmNum_ff;
   assign ahbTick = cc.ahbTick && busRunning;
   assign apbTick = cc.apbTick && busRunning;
   assign activeSrc = cc.activeSrc;
   assign ahbGateEn = ahbGate_ff;
   assign apbGateEn = apbGate_ff;
   assign periphGrant = grant_ff;

   // hsize is always a word on this bus
   logic unusedBits;
   assign unusedBits = ^{hsize, haddr[31:8]};
endmodule : power_mode_clock_sequencer

`default_nettype wire

// *** dv/power_mode_clock_sequencer_asserts.sv ***
// port assertions for the power mode and clock sequencer
// assumes a bind from the bench top and one clock domain
`timescale 1ns/10ps
`default_nettype none

module power_mode_clock_sequencer_asserts (
   input wire logic mclk,
   input wire logic rst,
   input wire logic waitInstr,
   input wire logic [15:0] periphReq,
   input wire logic [15:0] periphGrant,
   input wire logic [15:0] ahbGateEn,
   input wire logic [15:0] apbGateEn,
   input wire logic ahbTick,
   input wire logic apbTick,
   input wire logic coreHalt,
   input wire logic fetchFromRam,
   input wire logic lpOscSuspend,
   input wire logic pinLowPower,
   input wire logic ramRetainOnly,
   input wire logic sysResetReq,
   input wire logic [3:0] powerMode
);
   // one domain, reset masks every check
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   AST_RESET_RUN: assert property ($fell(rst) |-> powerMode == 4'h0 && !coreHalt && !fetchFromRam)
      else $error("run mode not entered after reset");
   AST_RAM_RUN: assert property (powerMode == 4'h1 |-> fetchFromRam && !coreHalt)
      else $error("ram run mode without ram fetch");
   AST_WAIT_HALT: assert property (waitInstr && powerMode inside {4'h0, 4'h1} && !coreHalt
      |=> coreHalt && powerMode inside {4'h2, 4'h3, 4'h9})
      else $error("wait instruction did not halt core");
   AST_CORE_GATES: assert property (powerMode == 4'h2 && $past(powerMode) == 4'h2
      |-> $stable(ahbGateEn) && $stable(apbGateEn))
      else $error("gates changed in core sleep");
   AST_BUS_STOP: assert property (lpOscSuspend && $past(lpOscSuspend)
      |-> ahbGateEn == 16'h0000 && apbGateEn == 16'h0000 && !ahbTick)
      else $error("bus clocks running in bus sleep");
   AST_OSC_SUSPEND: assert property ($rose(powerMode == 4'h3) |-> lpOscSuspend && coreHalt)
      else $error("oscillator not suspended in bus sleep");
   AST_APB_SYNC: assert property (apbTick |-> ahbTick)
      else $error("apb strobe without ahb strobe");
   AST_DEEP_ALL: assert property (powerMode == 4'h9
      |-> pinLowPower && ramRetainOnly && lpOscSuspend && !ahbTick && !apbTick)
      else $error("deep sleep not fully stopped");
   AST_DEEP_STAY: assert property (powerMode == 4'h9 |=> powerMode == 4'h9)
      else $error("deep sleep left without reset");
   AST_RESET_REQ: assert property ($rose(sysResetReq) |-> powerMode == 4'h9)
      else $error("reset request outside deep sleep");
   AST_GRANT: assert property (1'b1 |=> periphGrant == ($past(periphReq) & $past(ahbGateEn)
      & $past(apbGateEn)))
      else $error("access granted to gated peripheral");
endmodule : power_mode_clock_sequencer_asserts

`default_nettype wire

// *** dv/core_wait_model.sv ***
// core model: wait instruction after barriers, wake and reset levels
// assumes the bench requests sleep with a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none

module core_wait_model (
   input wire logic mclk,
   input wire logic sleepReq,
   input wire logic [7:0] wakeReq,
   input wire logic [3:0] rstReq,
   output logic waitInstr,
   output logic [7:0] wakeSrcIn,
   output logic [3:0] resetSrcIn
);
   logic [1:0] barrier_ff;

   // two barrier cycles drain bus traffic, then the wait pulse
   always_ff @(posedge mclk) begin
      barrier_ff <= {barrier_ff[0], sleepReq};
      waitInstr <= barrier_ff[1];
   end

   // wake interrupts are taken as high enough priority
   assign wakeSrcIn = wakeReq;
   assign resetSrcIn = rstReq;
endmodule : core_wait_model

`default_nettype wire

// *** dv/power_mode_clock_sequencer_test.sv ***
// self-checking bench for the power mode and clock sequencer
// assumes the core model as far side and an ahb-lite master in tasks
`timescale 1ns/10ps
`default_nettype none
`include "power_mode_clock_params.svh"

`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin err_total++; \
   $display("Error at %0t: got %h expected %h", $time, act, exp); end end

module power_mode_clock_sequencer_test;
   logic mclk, rst, hsel, hwrite, sleepReq, hreadyout, hresp, waitInstr, sysResetReq, ahbTick;
   logic rdPhase = 1'b0;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, g, m, e;
   logic [7:0] wakeReq, wakeSrcIn;
   logic [3:0] rstReq, resetSrcIn, powerMode, dv;
   logic [15:0] periphReq;
   logic hb, half;
   int err_total, check_count, seed, t0, n;
   int tickCnt = 0;
   logic [31:0] expQ[$], mskQ[$];
   int mhz[6] = '{0, 0, 20, 3, 25, 80};

   power_mode_clock_sequencer dut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .waitInstr, .wakeSrcIn, .resetSrcIn, .periphReq,
      .periphGrant(), .ahbGateEn(), .apbGateEn(), .ahbTick, .apbTick(), .activeSrc(), .coreHalt(),
      .fetchFromRam(), .lpOscSuspend(), .pinLowPower(), .ramRetainOnly(), .sysResetReq, .powerMode);
   core_wait_model core (.mclk, .sleepReq, .wakeReq, .rstReq, .waitInstr, .wakeSrcIn, .resetSrcIn);

   // clock generation
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // read data monitor and ahb strobe counter
   always @(posedge mclk) begin
      if (rdPhase && expQ.size() > 0) begin
         m = mskQ.pop_front();
         e = expQ.pop_front();
         `CHK(hrdata & m, e)
      end
      rdPhase <= hsel && htrans[1] && !hwrite && hreadyout;
      tickCnt <= tickCnt + int'(ahbTick);
   end

   task automatic conclude;
      if (expQ.size() != 0) begin
         err_total++; // reads never answered
      end
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude

   task automatic cyc(input int c);
      repeat (c) @(posedge mclk);
   endtask : cyc

   // one single ahb transfer: address phase, then data phase
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      for (k = 0; k < 2; k++) begin
         n = 0;
         do begin
            cyc(1);
            n++;
         end while (hreadyout !== 1'b1 && n < 50);
         if (n >= 50) begin
            err_total++;
            conclude();
         end
         // release only after the address phase, so a following call drives once
         if (k == 0) begin
            hsel <= 1'b0;
            htrans <= 2'b00;
            hwdata <= d;
         end
      end
   endtask : xfer

   task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [31:0] mk);
      expQ.push_back(ev);
      mskQ.push_back(mk);
      xfer(1'b0, a, 32'h0000_0000);
   endtask : rd

   task automatic doSleep;
      sleepReq <= 1'b1;
      cyc(1);
      sleepReq <= 1'b0;
      cyc(4);
   endtask : doSleep

   initial begin
      {hsel, hwrite, sleepReq} = 3'h0;
      {htrans, haddr, hwdata, wakeReq, rstReq, periphReq} = '0;
      {err_total, check_count} = '0;
      seed = 19578;
      rst = 1'b1;
      cyc(5);
      rst <= 1'b0;
      cyc(1);
      // reset values and an unmapped slot
      xfer(1'b1, 8'h1C, 32'hFFFF_FFFF);
      rd(`MODE_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
      rd(`CLKSEL_OFS, 32'h0000_0002, 32'hFFFF_FFFF);
      rd(`GATE_OFS, `GATE_RST, 32'hFFFF_FFFF);
      rd(`WAKEEN_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
      rd(`STATUS_OFS, 32'h0000_0020, 32'h0000_01FF);
      rd(8'h1C, 32'h0000_0000, 32'hFFFF_FFFF);
      // every source with a random divider and apb halving
      for (int s = 0; s < 6; s++) begin
         dv = 4'($random(seed)) & 4'h3;
         hb = 1'($random(seed));
         half = hb || (mhz[s] > 50 * (int'(dv) + 1));
         xfer(1'b1, `CLKSEL_OFS, {23'h0, hb, dv, 1'b0, 3'(s)});
         cyc(12);
         rd(`STATUS_OFS, {23'h0, half, 1'b0, 3'(s), 4'h0}, 32'h0000_01F0);
         t0 = tickCnt;
         cyc(24);
         `CHK(tickCnt - t0, 24 / (int'(dv) + 1))
      end
      xfer(1'b1, `CLKSEL_OFS, 32'h0000_0002);
      g = $random(seed) | 32'h0001_0001;
      periphReq <= 16'($random(seed));
      xfer(1'b1, `GATE_OFS, g);
      rd(`GATE_OFS, g, 32'hFFFF_FFFF);
      // core sleep from ram run: masked wake, then each source
      xfer(1'b1, `MODE_OFS, 32'h0000_0001);
      xfer(1'b1, `WAKEEN_OFS, 32'h0000_0010);
      doSleep();
      wakeReq <= 8'h01;
      cyc(6);
      rd(`STATUS_OFS, 32'h0000_0002, 32'h0000_000F);
      wakeReq <= 8'h00;
      cyc(4);
      xfer(1'b1, `WAKEEN_OFS, 32'h0000_00FF);
      for (int b = 0; b < 8; b++) begin
         doSleep();
         rd(`STATUS_OFS, 32'h0000_0002, 32'h0000_000F);
         wakeReq <= 8'h01 << b;
         cyc(6);
         wakeReq <= 8'h00;
         cyc(2);
         rd(`STATUS_OFS, 32'h0000_0001, 32'h0000_000F);
         rd(`CAUSE_OFS, 32'h0000_0001 << b, 32'h0000_00FF);
         xfer(1'b1, `CAUSE_OFS, 32'h0000_00FF);
      end
      // bus sleep with fast wake from the low frequency source
      xfer(1'b1, `MODE_OFS, 32'h0000_0006);
      doSleep();
      cyc(10);
      rd(`STATUS_OFS, 32'h0000_0013, 32'h0000_007F);
      wakeReq <= 8'h98;
      cyc(8);
      rd(`STATUS_OFS, 32'h0000_0003, 32'h0000_000F);
      wakeReq <= 8'h02;
      cyc(30);
      wakeReq <= 8'h00;
      rd(`STATUS_OFS, 32'h0000_0020, 32'h0000_007F);
      rd(`CAUSE_OFS, 32'h0000_0002, 32'h0000_0067);
      rd(`GATE_OFS, g, 32'hFFFF_FFFF);
      // deep sleep left only by an enabled reset source
      xfer(1'b1, `RSTEN_OFS, 32'h0000_0001);
      xfer(1'b1, `MODE_OFS, 32'h0000_0030);
      doSleep();
      rd(`STATUS_OFS, 32'h0000_0009, 32'h0000_000F);
      wakeReq <= 8'hFF;
      rstReq <= 4'h2;
      cyc(8);
      rd(`STATUS_OFS, 32'h0000_0009, 32'h0000_000F);
      wakeReq <= 8'h00;
      rstReq <= 4'h1;
      n = 0;
      while (sysResetReq !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      `CHK(sysResetReq, 1'b1)
      rst <= 1'b1;
      rstReq <= 4'h0;
      cyc(5);
      rst <= 1'b0;
      cyc(1);
      rd(`MODE_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
      rd(`STATUS_OFS, 32'h0000_0020, 32'h0000_01FF);
      cyc(4);
      conclude();
   end
endmodule : power_mode_clock_sequencer_test

bind power_mode_clock_sequencer power_mode_clock_sequencer_asserts chk (.mclk, .rst, .waitInstr, .periphReq,
   .periphGrant, .ahbGateEn, .apbGateEn, .ahbTick, .apbTick, .coreHalt, .fetchFromRam, .lpOscSuspend,
   .pinLowPower, .ramRetainOnly, .sysResetReq, .powerMode);

`default_nettype wire
